// [hdl/acs_pkg.sv]
// What this block does
// - mask bits 31..16 select cells, bit 31 cell 1, bit 16 cell 16
// - a set cell bit converts and reports that cell, a clear bit skips it
// - mask bits 15..8 select auxiliary inputs, bit 15 is input zero
// - bit 7 digital die temp, bit 6 analog die temp, bit 5 1.8 V supply
// - bit 2 converts and reports the 4.5 V reference, then ground
// - bit 1 sum monitor: twice the sample count, only their average reported
// - sum monitor with its enable clear measures ground instead
// - bit 0 selects pump monitor, ground measured instead when its enable is clear
// - order flag affects only cell and auxiliary averaging
// - repeat mode: all samples per channel, first cell or aux sample waits settle period
// - cycling mode: one sample per cell or aux channel per pass, cells, aux; rest as repeat
// - cycling mode waits voltage or auxiliary settle before sampling
// - high-side period times analog temp, ref, pump, sum, repeat cells
// - general period times digital temp and supply, repeat aux; no avg
// - count codes 0..5 give 1..32 samples; codes 6 and 7 act as code 5, 32 samples
// - samples averaged and convergent rounded to 16 bits
// - results sent high byte first, top mask bit first, unselected none
// - mask or setup written with the command is used by that command
package acs_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ACS_MASK_ADDR_B3 = 8'h03;
    localparam logic [7:0] ACS_MASK_ADDR_B2 = 8'h04;
    localparam logic [7:0] ACS_MASK_ADDR_B1 = 8'h05;
    localparam logic [7:0] ACS_MASK_ADDR_B0 = 8'h06;
    localparam logic [7:0] ACS_OVS_ADDR = 8'h07;
    localparam logic [31:0] ACS_MASK_RESET = 32'h0000_0000;
    localparam logic [7:0] ACS_OVS_RESET = 8'h00;
    localparam logic [7:0] ACS_RSVD_CLEAR = 8'he7;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int ACS_CELL_MSB = 31;
    localparam int ACS_AUX_MSB = 15;
    localparam int ACS_GT_BIT = 7;
    localparam int ACS_HT_BIT = 6;
    localparam int ACS_V18_BIT = 5;
    localparam int ACS_REF_BIT = 2;
    localparam int ACS_MOD_BIT = 1;
    localparam int ACS_PUMP_BIT = 0;
    localparam int ACS_ORDER_BIT = 7;
    localparam int ACS_HPER_LSB = 5;
    localparam int ACS_GPER_LSB = 3;
    localparam logic [2:0] ACS_CNT_MAX = 3'h5;
    // ---------------------------------------------------------------
    // conversion slots, in report order
    // ---------------------------------------------------------------
    localparam int ACS_NCELL = 16;
    localparam int ACS_NAUX = 8;
    localparam logic [4:0] ACS_SLOT_AUX = 5'h10;
    localparam logic [4:0] ACS_SLOT_GT = 5'h18;
    localparam logic [4:0] ACS_SLOT_HT = 5'h19;
    localparam logic [4:0] ACS_SLOT_V18 = 5'h1a;
    localparam logic [4:0] ACS_SLOT_REF = 5'h1b;
    localparam logic [4:0] ACS_SLOT_GND = 5'h1c;
    localparam logic [4:0] ACS_SLOT_MOD = 5'h1d;
    localparam logic [4:0] ACS_SLOT_PUMP = 5'h1e;
    localparam logic [4:0] ACS_SLOT_NONE = 5'h1f;
    localparam logic [1:0] ACS_GRP_CELL = 2'h0;
    localparam logic [1:0] ACS_GRP_AUX = 2'h1;
    localparam logic [1:0] ACS_GRP_REST = 2'h2;
    // ---------------------------------------------------------------
    // period selects toward the converter
    // ---------------------------------------------------------------
    localparam logic [1:0] ACS_PER_VOL = 2'h0;
    localparam logic [1:0] ACS_PER_AUX = 2'h1;
    localparam logic [1:0] ACS_PER_HIGH = 2'h2;
    localparam logic [1:0] ACS_PER_GEN = 2'h3;
    typedef enum logic [4:0] {
        ACS_ST_IDLE = 5'h01,
        ACS_ST_PICK = 5'h02,
        ACS_ST_CONV = 5'h04,
        ACS_ST_LOAD = 5'h08,
        ACS_ST_SEND = 5'h10
    } acs_state_type;
endpackage

// [hdl/acs_channel_sequencer.sv]
`timescale 1ns/1ps
module acs_channel_sequencer #(
    parameter int ACC_W = 22
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register access from the frame decoder
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // command
    input wire logic cmd_start,
    input wire logic cmd_respond,
    output logic cmd_busy,
    // test configuration enables
    input wire logic cell_sum_monitor_enable,
    input wire logic pump_monitor_enable,
    // converter
    output logic adc_start,
    output logic [4:0] adc_channel,
    output logic [1:0] adc_period_sel,
    output logic [1:0] high_side_avg_period,
    output logic [1:0] general_avg_period,
    input wire logic adc_done,
    input wire logic [15:0] adc_data,
    // result bytes
    output logic res_valid,
    output logic [7:0] res_byte,
    input wire logic res_ready
);
    import acs_pkg::*;

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    function automatic logic [30:0] slot_vec(input logic [31:0] m);
        logic [30:0] v;
        v = '0;
        for (int i = 0; i < ACS_NCELL; i++) begin
            v[i] = m[ACS_CELL_MSB - i];
        end
        for (int i = 0; i < ACS_NAUX; i++) begin
            v[int'(ACS_SLOT_AUX) + i] = m[ACS_AUX_MSB - i];
        end
        v[ACS_SLOT_GT] = m[ACS_GT_BIT];
        v[ACS_SLOT_HT] = m[ACS_HT_BIT];
        v[ACS_SLOT_V18] = m[ACS_V18_BIT];
        v[ACS_SLOT_REF] = m[ACS_REF_BIT];
        v[ACS_SLOT_GND] = m[ACS_REF_BIT];
        v[ACS_SLOT_MOD] = m[ACS_MOD_BIT];
        v[ACS_SLOT_PUMP] = m[ACS_PUMP_BIT];
        return v;
    endfunction

    function automatic logic [4:0] first_sel(input logic [30:0] v,
            input logic [4:0] from, input logic [4:0] hi);
        logic [4:0] r;
        r = ACS_SLOT_NONE;
        for (int i = 30; i >= 0; i--) begin
            if (v[i] && 5'(i) >= from && 5'(i) <= hi) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] round_avg(input logic [ACC_W-1:0] a,
            input logic [2:0] sh);
        logic [ACC_W-1:0] q;
        logic [ACC_W-1:0] rem;
        logic [ACC_W-1:0] half;
        q = a >> sh;
        rem = a - (q << sh);
        half = (sh == 3'h0) ? '0 : ({{(ACC_W-1){1'b0}}, 1'b1} << (sh - 3'h1));
        if (sh != 3'h0 && (rem > half || (rem == half && q[0]))) begin
            q = q + ACC_W'(1);
        end
        return q[15:0];
    endfunction

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [31:0] mask_q;
    logic [31:0] mask_d;
    logic [7:0] ovs_q;
    logic [7:0] ovs_d;
    logic [7:0] rdata_q;

    always_comb begin
        mask_d = mask_q;
        ovs_d = ovs_q;
        if (reg_wr_en) begin
            case (reg_addr)
                ACS_MASK_ADDR_B3: mask_d[31:24] = reg_wdata;
                ACS_MASK_ADDR_B2: mask_d[23:16] = reg_wdata;
                ACS_MASK_ADDR_B1: mask_d[15:8] = reg_wdata;
                ACS_MASK_ADDR_B0: mask_d[7:0] = reg_wdata & ACS_RSVD_CLEAR;
                ACS_OVS_ADDR: ovs_d = reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= ACS_MASK_RESET;
            ovs_q <= ACS_OVS_RESET;
        end else begin
            mask_q <= mask_d;
            ovs_q <= ovs_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                ACS_MASK_ADDR_B3: rdata_q <= mask_q[31:24];
                ACS_MASK_ADDR_B2: rdata_q <= mask_q[23:16];
                ACS_MASK_ADDR_B1: rdata_q <= mask_q[15:8];
                ACS_MASK_ADDR_B0: rdata_q <= mask_q[7:0];
                ACS_OVS_ADDR: rdata_q <= ovs_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_q;
    assign high_side_avg_period = ovs_q[ACS_HPER_LSB +: 2];
    assign general_avg_period = ovs_q[ACS_GPER_LSB +: 2];

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    acs_state_type state_q;
    logic [30:0] run_sel_q;
    logic [2:0] code_q;
    logic cyc_q;
    logic respond_q;
    logic [4:0] slot_q;
    logic [1:0] grp_q;
    logic [5:0] pass_q;
    logic [6:0] samp_q;
    logic [4:0] conv_slot_q;
    logic first_q;
    logic last_q;
    logic start_q;
    logic [4:0] chan_q;
    logic [1:0] per_q;
    logic lo_q;
    logic valid_q;
    logic [7:0] byte_q;
    logic [ACC_W-1:0] acc_mem [0:30];
    logic [15:0] res_mem [0:30];

    logic cyc_act;
    logic [4:0] grp_hi;
    logic [4:0] nxt;
    logic [5:0] n_pass;
    logic [6:0] cnt_slot;
    logic [2:0] sh_slot;
    logic first_smp;
    logic last_smp;
    logic [1:0] per_sel;
    logic [4:0] chan_sel;
    logic [ACC_W-1:0] acc_new;
    logic [2:0] code_d;

    assign code_d = (ovs_d[2:0] > ACS_CNT_MAX) ? ACS_CNT_MAX : ovs_d[2:0];
    assign cyc_act = cyc_q && (grp_q != ACS_GRP_REST);
    assign grp_hi = (grp_q == ACS_GRP_CELL) ? ACS_SLOT_AUX - 5'h1 :
        (grp_q == ACS_GRP_AUX) ? ACS_SLOT_GT - 5'h1 : ACS_SLOT_PUMP;
    assign nxt = first_sel(run_sel_q, slot_q, grp_hi);
    assign n_pass = 6'h01 << code_q;

    always_comb begin
        cnt_slot = 7'h01 << code_q;
        sh_slot = code_q;
        if (nxt == ACS_SLOT_GT) begin
            cnt_slot = 7'h01;
            sh_slot = 3'h0;
        end else if (nxt == ACS_SLOT_MOD) begin
            cnt_slot = 7'h02 << code_q;
            sh_slot = code_q + 3'h1;
        end
    end

    assign first_smp = cyc_act ? (pass_q == 6'h00) : (samp_q == 7'h00);
    assign last_smp = cyc_act ? (pass_q == n_pass - 6'h01) :
        (samp_q == cnt_slot - 7'h01);

    always_comb begin
        if (cyc_act) begin
            per_sel = (grp_q == ACS_GRP_CELL) ? ACS_PER_VOL : ACS_PER_AUX;
        end else if (nxt < ACS_SLOT_AUX) begin
            per_sel = first_smp ? ACS_PER_VOL : ACS_PER_HIGH;
        end else if (nxt < ACS_SLOT_GT) begin
            per_sel = first_smp ? ACS_PER_AUX : ACS_PER_GEN;
        end else if (nxt == ACS_SLOT_GT || nxt == ACS_SLOT_V18) begin
            per_sel = ACS_PER_GEN;
        end else begin
            per_sel = ACS_PER_HIGH;
        end
    end

    always_comb begin
        chan_sel = nxt;
        if (nxt == ACS_SLOT_MOD && !cell_sum_monitor_enable) begin
            chan_sel = ACS_SLOT_GND;
        end else if (nxt == ACS_SLOT_PUMP && !pump_monitor_enable) begin
            chan_sel = ACS_SLOT_GND;
        end
    end

    assign acc_new = first_q ? ACC_W'(adc_data) :
        acc_mem[conv_slot_q] + ACC_W'(adc_data);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ACS_ST_IDLE;
            run_sel_q <= '0;
            code_q <= 3'h0;
            cyc_q <= 1'b0;
            respond_q <= 1'b0;
            slot_q <= 5'h00;
            grp_q <= ACS_GRP_REST;
            pass_q <= 6'h00;
            samp_q <= 7'h00;
            conv_slot_q <= 5'h00;
            first_q <= 1'b0;
            last_q <= 1'b0;
            start_q <= 1'b0;
            chan_q <= 5'h00;
            per_q <= ACS_PER_VOL;
            lo_q <= 1'b0;
            valid_q <= 1'b0;
            byte_q <= 8'h00;
        end else begin
            start_q <= 1'b0;
            case (state_q)
                ACS_ST_IDLE: begin
                    if (cmd_start) begin
                        run_sel_q <= slot_vec(mask_d);
                        code_q <= code_d;
                        cyc_q <= ovs_d[ACS_ORDER_BIT];
                        respond_q <= cmd_respond;
                        slot_q <= 5'h00;
                        grp_q <= ovs_d[ACS_ORDER_BIT] ? ACS_GRP_CELL :
                            ACS_GRP_REST;
                        pass_q <= 6'h00;
                        samp_q <= 7'h00;
                        state_q <= ACS_ST_PICK;
                    end
                end
                ACS_ST_PICK: begin
                    if (nxt == ACS_SLOT_NONE) begin
                        if (cyc_act && pass_q != n_pass - 6'h01) begin
                            pass_q <= pass_q + 6'h01;
                            slot_q <= (grp_q == ACS_GRP_CELL) ? 5'h00 :
                                ACS_SLOT_AUX;
                        end else if (cyc_act) begin
                            pass_q <= 6'h00;
                            grp_q <= grp_q + 2'h1;
                            slot_q <= (grp_q == ACS_GRP_CELL) ? ACS_SLOT_AUX :
                                ACS_SLOT_GT;
                        end else begin
                            slot_q <= 5'h00;
                            state_q <= respond_q ? ACS_ST_LOAD : ACS_ST_IDLE;
                        end
                    end else begin
                        start_q <= 1'b1;
                        chan_q <= chan_sel;
                        per_q <= per_sel;
                        conv_slot_q <= nxt;
                        first_q <= first_smp;
                        last_q <= last_smp;
                        slot_q <= nxt;
                        state_q <= ACS_ST_CONV;
                    end
                end
                ACS_ST_CONV: begin
                    if (adc_done) begin
                        state_q <= ACS_ST_PICK;
                        if (cyc_act || last_q) begin
                            samp_q <= 7'h00;
                            slot_q <= slot_q + 5'h01;
                        end else begin
                            samp_q <= samp_q + 7'h01;
                        end
                    end
                end
                ACS_ST_LOAD: begin
                    if (nxt == ACS_SLOT_NONE) begin
                        state_q <= ACS_ST_IDLE;
                    end else begin
                        byte_q <= res_mem[nxt][15:8];
                        valid_q <= 1'b1;
                        lo_q <= 1'b0;
                        slot_q <= nxt;
                        state_q <= ACS_ST_SEND;
                    end
                end
                ACS_ST_SEND: begin
                    if (res_ready && !lo_q) begin
                        byte_q <= res_mem[slot_q][7:0];
                        lo_q <= 1'b1;
                    end else if (res_ready) begin
                        valid_q <= 1'b0;
                        slot_q <= slot_q + 5'h01;
                        state_q <= ACS_ST_LOAD;
                    end
                end
                default: state_q <= ACS_ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // accumulation and rounding
    // ---------------------------------------------------------------
    logic [2:0] conv_sh;
    assign conv_sh = (conv_slot_q == ACS_SLOT_GT) ? 3'h0 :
        (conv_slot_q == ACS_SLOT_MOD) ? code_q + 3'h1 : code_q;

    always_ff @(posedge core_clk) begin
        if (state_q == ACS_ST_CONV && adc_done) begin
            acc_mem[conv_slot_q] <= acc_new;
            if (last_q) begin
                res_mem[conv_slot_q] <= round_avg(acc_new, conv_sh);
            end
        end
    end

    assign adc_start = start_q;
    assign adc_channel = chan_q;
    assign adc_period_sel = per_q;
    assign res_valid = valid_q;
    assign res_byte = byte_q;
    assign cmd_busy = (state_q != ACS_ST_IDLE);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_hi_byte;
        res_valid && res_ready && !lo_q;
    endsequence
    sequence s_lo_byte;
        res_valid && lo_q;
    endsequence

    AST_CELL_SELECTED: assert property (
        adc_start && conv_slot_q < ACS_SLOT_AUX |->
            adc_channel == conv_slot_q && run_sel_q[conv_slot_q])
        else $error("cell converted without its select bit");
    AST_ONLY_SELECTED: assert property (
        adc_start |-> run_sel_q[conv_slot_q])
        else $error("unselected slot converted");
    AST_SUM_GROUND: assert property (
        adc_start && conv_slot_q == ACS_SLOT_MOD && !cell_sum_monitor_enable
            |-> adc_channel == ACS_SLOT_GND)
        else $error("disabled sum monitor not routed to ground");
    AST_PUMP_GROUND: assert property (
        adc_start && conv_slot_q == ACS_SLOT_PUMP && !pump_monitor_enable
            |-> adc_channel == ACS_SLOT_GND)
        else $error("disabled pump monitor not routed to ground");
    AST_DIGTEMP_GEN: assert property (
        adc_start && conv_slot_q == ACS_SLOT_GT |->
            adc_period_sel == ACS_PER_GEN && last_q)
        else $error("digital temperature averaged or mistimed");
    AST_CYCLE_SETTLE: assert property (
        adc_start && cyc_q && grp_q == ACS_GRP_CELL |->
            adc_period_sel == ACS_PER_VOL)
        else $error("cycling cell sample without voltage settle");
    AST_REPEAT_HIGH: assert property (
        adc_start && !cyc_q && conv_slot_q < ACS_SLOT_AUX && !first_q
            |-> adc_period_sel == ACS_PER_HIGH)
        else $error("repeat cell sample not on high-side period");
    AST_CYCLE_GROUPS: assert property (
        adc_start && cyc_q && grp_q == ACS_GRP_AUX |->
            conv_slot_q >= ACS_SLOT_AUX && conv_slot_q < ACS_SLOT_GT)
        else $error("cycling group order broken");
    AST_MSB_FIRST: assert property (
        s_hi_byte |=> s_lo_byte)
        else $error("low byte did not follow high byte");
    AST_SAME_FRAME: assert property (
        state_q == ACS_ST_IDLE && cmd_start && reg_wr_en &&
            reg_addr == ACS_OVS_ADDR |=>
            cyc_q == $past(reg_wdata[ACS_ORDER_BIT]))
        else $error("same-frame setup write not used");
endmodule

// [testbench/adc_command_channel_oversample_config_tb.sv]
`timescale 1ns/1ps
module adc_command_channel_oversample_config_tb;
    import acs_pkg::*;
    // ---------------------------------------------------------------
    // signals and converter stand-in
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [31:0] m;
        logic [7:0] s;
        logic se;
        logic pe;
        logic rp;
        logic dbl;
        logic mg;
    } acs_row_type;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic cmd_start = 1'b0;
    logic cmd_respond = 1'b0;
    logic cmd_busy;
    logic sum_en = 1'b1;
    logic pump_en = 1'b1;
    logic adc_start;
    logic [4:0] adc_channel;
    logic [1:0] adc_period_sel;
    logic [1:0] hper;
    logic [1:0] gper;
    logic adc_done = 1'b0;
    logic [15:0] adc_data = 16'h0000;
    logic res_valid;
    logic [7:0] res_byte;
    logic res_ready = 1'b1;
    int fail_count = 0;
    int n_compared = 0;
    int tmr = 0;
    logic [4:0] cur_ch = 5'h00;
    int cnt [32];
    int ec [32];
    int sl [$];
    int rps [$];
    int ss [$];
    logic [6:0] act_q [$];
    logic [6:0] exp_q [$];
    logic [7:0] got_b [$];
    logic [7:0] exp_b [$];
    acs_row_type rows [7];

    acs_channel_sequencer dut (
        .core_clk(core_clk), .rst_n(rst_n),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cmd_start(cmd_start), .cmd_respond(cmd_respond),
        .cmd_busy(cmd_busy), .cell_sum_monitor_enable(sum_en),
        .pump_monitor_enable(pump_en), .adc_start(adc_start),
        .adc_channel(adc_channel), .adc_period_sel(adc_period_sel),
        .high_side_avg_period(hper), .general_avg_period(gper),
        .adc_done(adc_done), .adc_data(adc_data),
        .res_valid(res_valid), .res_byte(res_byte), .res_ready(res_ready)
    );

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        adc_done <= (tmr == 1);
        res_ready <= ~res_ready;
        if (res_valid === 1'b1 && res_ready === 1'b1) begin
            got_b.push_back(res_byte);
        end
        if (tmr == 1) begin
            adc_data <= {3'h0, cur_ch, 8'h01} + 16'(cnt[cur_ch] % 2);
            cnt[cur_ch]++;
        end
        if (tmr != 0) begin
            tmr = tmr - 1;
        end
        if (adc_start === 1'b1) begin
            cur_ch = adc_channel;
            tmr = 3;
            act_q.push_back({adc_channel, adc_period_sel});
        end
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic print_verdict();
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, e);
    endtask

    task automatic smp(input int j, input int per);
        ss[j] += sl[j] * 256 + 1 + ec[sl[j]] % 2;
        ec[sl[j]]++;
        exp_q.push_back(7'(sl[j] * 4 + per));
    endtask

    task automatic build(input acs_row_type r);
        int k, n, j, p, c, b, q, v;
        exp_q.delete();
        exp_b.delete();
        sl.delete();
        rps.delete();
        ss.delete();
        foreach (ec[i]) ec[i] = 0;
        k = (r.s[2:0] > ACS_CNT_MAX) ? 5 : int'(r.s[2:0]);
        n = 1 << k;
        for (c = 0; c < 31; c++) begin
            b = (c < 27) ? 31 - c : (c < 29) ? 2 : 30 - c;
            if (r.m[b]) begin
                sl.push_back(((c == 29 && !r.se) || (c == 30 && !r.pe)) ? 28 : c);
                rps.push_back(c == 24 ? 1 : (c == 29 ? 2 * n : n));
                ss.push_back(0);
            end
        end
        if (r.s[7]) begin
            for (b = 0; b < 2; b++) begin
                for (p = 0; p < n; p++) begin
                    foreach (sl[j]) if (sl[j] >= 16 * b && sl[j] < 16 + 8 * b)
                        smp(j, b);
                end
            end
        end
        foreach (sl[j]) begin
            if (!r.s[7] || sl[j] >= 24) begin
                for (p = 0; p < rps[j]; p++) begin
                    c = sl[j] < 16 ? (p > 0 ? 2 : 0) : sl[j] < 24 ? (p > 0 ? 3 : 1)
                        : (sl[j] == 24 || sl[j] == 26) ? 3 : 2;
                    smp(j, c);
                end
            end
            c = rps[j];
            q = ss[j] >> $clog2(c);
            v = ss[j] % c;
            if (c > 1 && (v > c / 2 || (v == c / 2 && q % 2 == 1))) q++;
            if (r.rp) exp_b.push_back(q[15:8]);
            if (r.rp) exp_b.push_back(q[7:0]);
        end
    endtask

    task automatic run(input acs_row_type r);
        int i;
        sum_en <= r.se;
        pump_en <= r.pe;
        wr(8'h03, r.m[31:24]);
        wr(8'h04, r.m[23:16]);
        wr(8'h05, r.m[15:8]);
        if (!r.mg || !r.se) wr(8'h06, r.m[7:0]);
        if (!r.mg || r.se) wr(8'h07, r.s);
        build(r);
        act_q.delete();
        got_b.delete();
        foreach (cnt[i]) cnt[i] = 0;
        @(posedge core_clk);
        cmd_start <= 1'b1;
        cmd_respond <= r.rp;
        reg_wr_en <= r.mg;
        reg_addr <= r.se ? 8'h06 : 8'h07;
        reg_wdata <= r.se ? r.m[7:0] : r.s;
        @(posedge core_clk);
        cmd_start <= 1'b0;
        reg_wr_en <= 1'b0;
        #1;
        chk(cmd_busy, 32'h1);
        if (r.dbl) begin
            @(posedge core_clk);
            cmd_start <= 1'b1;
            cmd_respond <= 1'b1;
            @(posedge core_clk);
            cmd_start <= 1'b0;
        end
        for (i = 0; i < 30000 && cmd_busy !== 1'b0; i++) begin
            @(posedge core_clk);
            #1;
        end
        if (cmd_busy !== 1'b0) fail_count++;
        if (cmd_busy !== 1'b0) print_verdict();
        repeat (4) @(posedge core_clk);
        chk(hper, r.s[6:5]);
        chk(gper, r.s[4:3]);
        chk(act_q.size(), exp_q.size());
        for (i = 0; i < exp_q.size() && i < act_q.size(); i++)
            chk(act_q[i], exp_q[i]);
        chk(got_b.size(), exp_b.size());
        for (i = 0; i < exp_b.size() && i < got_b.size(); i++)
            chk(got_b[i], exp_b[i]);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [7:0] wd [6];
        logic [7:0] ex [6];
        wd = '{8'ha5, 8'h5a, 8'hc3, 8'hff, 8'hff, 8'h55};
        ex = '{8'ha5, 8'h5a, 8'hc3, 8'he7, 8'hff, 8'h00};
        rows[0] = '{32'h8000_0000, 8'h60, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        rows[1] = '{32'hc001_8000, 8'h79, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        rows[2] = '{32'hc001_8000, 8'hfa, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        rows[3] = '{32'h0000_00e7, 8'h7b, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        rows[4] = '{32'h0000_00e7, 8'h61, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        rows[5] = '{32'h0001_0100, 8'h7e, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        rows[6] = '{32'h0000_8100, 8'hff, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) run(rows[i]);
        for (int i = 0; i < 6; i++) wr(8'(3 + i), wd[i]);
        for (int i = 0; i < 6; i++) rd(8'(3 + i), ex[i]);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(cmd_busy, 32'h0);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rd(8'(3 + i), 8'h00);
        print_verdict();
    end
endmodule
